// [hw/tcs_defines.vh]
// constants for the type-c source attach and bmc transmit block
// included by the design files of this block only
`ifndef TCS_DEFINES_VH
`define TCS_DEFINES_VH

`define TCS_CLK_HZ          10000000
`define TCS_DEB_MS          185
`define TCS_DEB_CYC         ((`TCS_CLK_HZ / 1000) * `TCS_DEB_MS)
`define TCS_DISCHARGE_PIN_MS         650
`define TCS_DISCHARGE_PIN_CYC        ((`TCS_CLK_HZ / 1000) * `TCS_DISCHARGE_PIN_MS)
`define TCS_UI_HALF_CYC     16'd17

`define TCS_ST_UNATT        3'h0
`define TCS_ST_SLEEP        3'h1
`define TCS_ST_ATT3A        3'h2
`define TCS_ST_ATT15        3'h3
`define TCS_ST_DISCHARGE_PIN         3'h4

`define TCS_RP_OFF          2'h0
`define TCS_RP_STD          2'h1
`define TCS_RP_3A0          2'h2
`define TCS_RP_1A5          2'h3

`define TCS_CAP_DATA_BIT    25

`endif

// [hw/tcs_bmc_tx.v]
// biphase mark encoder for the cc line
// assumes bit_valid stands while a bit is owed; in the bit_ready cycle it says whether
// another bit follows, so the source drops it there for the last bit
`timescale 1ns/1ns
`include "tcs_defines.vh"

module tcs_bmc_tx #(
    parameter HALF_CYC = `TCS_UI_HALF_CYC
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        bit_valid,
    input  wire        bit_data,
    output wire        bit_ready,
    output reg         line_out,
    output reg         busy
);
    reg  [15:0] cnt_reg;
    reg         half_reg;
    wire        tick = (cnt_reg == HALF_CYC - 16'd1);

    assign bit_ready = busy & tick & half_reg;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_reg  <= 16'h0000;
            half_reg <= 1'b0;
            line_out <= 1'b0;
            busy     <= 1'b0;
        end else if (!busy) begin
            cnt_reg  <= 16'h0000;
            half_reg <= 1'b0;
            if (bit_valid) begin
                busy <= 1'b1;
            end
        end else if (tick) begin
            cnt_reg <= 16'h0000;
            if (!half_reg) begin
                half_reg <= 1'b1;
                if (bit_data) begin
                    line_out <= ~line_out;
                end
            end else begin
                half_reg <= 1'b0;
                line_out <= ~line_out;
                busy     <= bit_valid;
            end
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end
endmodule // tcs_bmc_tx

// [hw/tcs_source_ctrl.v]
// type-c source attach control with bmc transmit of pd messages
// assumes analog comparators are already synchronous to ref_clk
// msg_word is captured in the msg_start cycle only
// Operation
// - attach on one cc window, debounced, vbus low
// - after attach: vbus on, other rp off, 3a
// - pd-capable sink moves rp to 1.5a
// - detach threshold removes vbus, resume watching
// - both cc high debounced enters sleep
// - bmc: edge each bit end, ones mid
// - tx bias rail high only while sending
// - source caps usb data flag forced zero
// - bleed pulldown from attach until contract
// - supply bleed current from attach until contract
// - first overtemp threshold stops discharge transistor
// - check supply sense before gate drive on
// - 5 v default, higher only negotiated
// - attach indicator low after debounce
// - slow discharge: hard reset, then retry
`timescale 1ns/1ns
`include "tcs_defines.vh"

module tcs_source_ctrl #(
    parameter DEB_CYC  = `TCS_DEB_CYC,
    parameter DISCHARGE_PIN_CYC = `TCS_DISCHARGE_PIN_CYC,
    parameter MSG_BITS = 32
) (
    input  wire                ref_clk,
    input  wire                reset,
    input  wire                cc1_in_window,
    input  wire                cc2_in_window,
    input  wire                cc1_above_rd,
    input  wire                cc2_above_rd,
    input  wire                cc_detach,
    input  wire                vbus_low,
    input  wire                vbus_safe0,
    input  wire                wake_cmp,
    input  wire                supply_ok,
    input  wire                sink_pd_capable,
    input  wire                contract_done,
    input  wire                hi_volt_agreed,
    input  wire                overtemp_threshold_one,
    input  wire                msg_start,
    input  wire                msg_is_caps,
    input  wire [MSG_BITS-1:0] msg_word,
    output reg  [1:0]          cc1_rp_sel,
    output reg  [1:0]          cc2_rp_sel,
    output reg                 sleep_mode,
    output reg                 orient_cc2,
    output reg                 vbus_gate_drive,
    output reg                 attach_indicator_out_n,
    output reg                 bleed_pulldown,
    output reg                 supply_bleed_current,
    output reg                 discharge_pin,
    output reg                 overtemp_shutdown,
    output reg                 sel_high_volt,
    output reg                 hard_reset_req,
    output reg                 tx_bias_rail,
    output wire                tx_line,
    output wire                tx_busy
);
    reg  [2:0]          state_reg;
    reg  [31:0]         deb_reg;
    reg  [31:0]         discharge_pin_reg;
    reg  [MSG_BITS-1:0] sh_reg;
    reg  [7:0]          left_reg;
    reg                 deb_att_reg;    // 1 while the debounce counter times an attach
    wire                one_cc = cc1_in_window ^ cc2_in_window;
    wire                att_ok = one_cc & vbus_low;
    wire                both_hi = cc1_above_rd & cc2_above_rd;
    wire                attached = (state_reg == `TCS_ST_ATT3A) |
                                   (state_reg == `TCS_ST_ATT15);
    wire                bit_ready;
    wire                deb_done = (deb_reg == DEB_CYC - 1);
    // valid must fall in the cycle the last bit is taken, otherwise the encoder
    // would run one extra bit after the bit count has already reached zero
    wire                bits_left = (left_reg != 8'h00) &
                                    ~(bit_ready & (left_reg == 8'h01));

    tcs_bmc_tx u_bmc (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .bit_valid (bits_left),
        .bit_data  (sh_reg[0]),
        .bit_ready (bit_ready),
        .line_out  (tx_line),
        .busy      (tx_busy)
    );

    // message shifter; the caps data flag is cleared on the way in
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            sh_reg       <= {MSG_BITS{1'b0}};
            left_reg     <= 8'h00;
            tx_bias_rail <= 1'b0;
        end else begin
            if (msg_start && left_reg == 8'h00 && !tx_busy && attached) begin
                sh_reg   <= msg_word;
                if (msg_is_caps) begin
                    sh_reg[`TCS_CAP_DATA_BIT] <= 1'b0;
                end
                left_reg <= MSG_BITS[7:0];
            end else if (bit_ready && left_reg != 8'h00) begin
                sh_reg   <= sh_reg >> 1;
                left_reg <= left_reg - 8'h01;
            end
            // one flop late, so the rail still covers the closing edge of the last bit
            tx_bias_rail <= (left_reg != 8'h00) | tx_busy;
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg              <= `TCS_ST_UNATT;
            deb_reg                <= 32'h0;
            deb_att_reg            <= 1'b0;
            discharge_pin_reg               <= 32'h0;
            cc1_rp_sel             <= `TCS_RP_STD;
            cc2_rp_sel             <= `TCS_RP_STD;
            sleep_mode             <= 1'b0;
            orient_cc2             <= 1'b0;
            vbus_gate_drive        <= 1'b0;
            attach_indicator_out_n <= 1'b1;
            bleed_pulldown         <= 1'b0;
            supply_bleed_current   <= 1'b0;
            discharge_pin          <= 1'b0;
            overtemp_shutdown      <= 1'b0;
            sel_high_volt          <= 1'b0;
            hard_reset_req         <= 1'b0;
        end else begin
            hard_reset_req    <= 1'b0;
            // one flop behind the comparator, no hysteresis of its own
            overtemp_shutdown <= overtemp_threshold_one;
            case (state_reg)
                `TCS_ST_UNATT, `TCS_ST_SLEEP: begin
                    sleep_mode <= (state_reg == `TCS_ST_SLEEP);
                    if (att_ok) begin
                        if (!deb_att_reg) begin
                            // counter was timing sleep: attach time starts afresh
                            deb_reg     <= 32'h1;
                            deb_att_reg <= 1'b1;
                        end else if (deb_done && supply_ok) begin
                            deb_reg                <= 32'h0;
                            state_reg              <= `TCS_ST_ATT3A;
                            orient_cc2             <= cc2_in_window;
                            vbus_gate_drive        <= 1'b1;
                            cc1_rp_sel <= cc1_in_window ? `TCS_RP_3A0 : `TCS_RP_OFF;
                            cc2_rp_sel <= cc2_in_window ? `TCS_RP_3A0 : `TCS_RP_OFF;
                            attach_indicator_out_n <= 1'b0;
                            bleed_pulldown         <= 1'b1;
                            supply_bleed_current   <= 1'b1;
                            sleep_mode             <= 1'b0;
                        end else if (!deb_done) begin
                            deb_reg <= deb_reg + 32'h1;
                        end
                    end else if (both_hi && state_reg == `TCS_ST_UNATT) begin
                        // sleep uses the same debounce counter
                        if (deb_att_reg) begin
                            deb_reg     <= 32'h1;
                            deb_att_reg <= 1'b0;
                        end else if (deb_done) begin
                            deb_reg   <= 32'h0;
                            state_reg <= `TCS_ST_SLEEP;
                        end else begin
                            deb_reg <= deb_reg + 32'h1;
                        end
                    end else begin
                        deb_reg <= 32'h0;
                        if (state_reg == `TCS_ST_SLEEP && !wake_cmp && !both_hi) begin
                            state_reg <= `TCS_ST_UNATT;
                        end
                    end
                end
                `TCS_ST_ATT3A, `TCS_ST_ATT15: begin
                    if (sink_pd_capable) begin
                        state_reg <= `TCS_ST_ATT15;
                        // only the connected pin carries rp; the other stays off
                        if (orient_cc2) begin
                            cc2_rp_sel <= `TCS_RP_1A5;
                        end else begin
                            cc1_rp_sel <= `TCS_RP_1A5;
                        end
                    end
                    if (contract_done) begin
                        bleed_pulldown       <= 1'b0;
                        supply_bleed_current <= 1'b0;
                    end
                    // higher voltage only once a contract names it
                    sel_high_volt <= contract_done & hi_volt_agreed;
                    // bleeds come back on so the supply falls while vbus discharges
                    if (cc_detach) begin
                        state_reg       <= `TCS_ST_DISCHARGE_PIN;
                        vbus_gate_drive <= 1'b0;
                        sel_high_volt   <= 1'b0;
                        attach_indicator_out_n <= 1'b1;
                        bleed_pulldown  <= 1'b1;
                        supply_bleed_current <= 1'b1;
                        discharge_pin_reg        <= 32'h0;
                    end
                end
                // discharge retries with a hard reset until vbus reads safe
                default: begin
                    discharge_pin <= ~overtemp_threshold_one;
                    cc1_rp_sel    <= `TCS_RP_STD;
                    cc2_rp_sel    <= `TCS_RP_STD;
                    if (vbus_safe0) begin
                        state_reg      <= `TCS_ST_UNATT;
                        discharge_pin  <= 1'b0;
                        bleed_pulldown <= 1'b0;
                        supply_bleed_current <= 1'b0;
                    end else if (discharge_pin_reg == DISCHARGE_PIN_CYC - 1) begin
                        hard_reset_req <= 1'b1;
                        discharge_pin_reg       <= 32'h0;
                    end else begin
                        discharge_pin_reg <= discharge_pin_reg + 32'h1;
                    end
                end
            endcase
        end
    end
endmodule // tcs_source_ctrl

// [verif/tcs_ctrl_monitor.sv]
// checker for the source controller: attach, bleed, rail, detach
// assumes it is bound to every tcs_source_ctrl instance
`timescale 1ns/1ns
module tcs_ctrl_monitor (
    input wire       ref_clk,
    input wire       reset,
    input wire       cc1_in_window,
    input wire       cc2_in_window,
    input wire       cc1_above_rd,
    input wire       cc2_above_rd,
    input wire       cc_detach,
    input wire       vbus_low,
    input wire       supply_ok,
    input wire       overtemp_threshold_one,
    input wire [1:0] cc1_rp_sel,
    input wire [1:0] cc2_rp_sel,
    input wire       sleep_mode,
    input wire       orient_cc2,
    input wire       vbus_gate_drive,
    input wire       attach_indicator_out_n,
    input wire       bleed_pulldown,
    input wire       supply_bleed_current,
    input wire       discharge_pin,
    input wire       overtemp_shutdown,
    input wire       tx_bias_rail,
    input wire       tx_busy
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_att;
        $rose(vbus_gate_drive) |-> $past(supply_ok && vbus_low && (cc1_in_window ^ cc2_in_window));
    endproperty
    a_att: assert property (p_att) else $error("gate on without attach");
    property p_rp;
        $rose(vbus_gate_drive) |-> {cc1_rp_sel, cc2_rp_sel} == (orient_cc2 ? 4'h2 : 4'h8);
    endproperty
    a_rp: assert property (p_rp) else $error("bad rp on attach");
    property p_ind; $fell(attach_indicator_out_n) |-> vbus_gate_drive; endproperty
    a_ind: assert property (p_ind) else $error("indicator early");
    property p_bleed; $rose(vbus_gate_drive) |-> bleed_pulldown && supply_bleed_current; endproperty
    a_bleed: assert property (p_bleed) else $error("bleed off at attach");
    property p_rail; tx_bias_rail |-> tx_busy || $past(tx_busy); endproperty
    a_rail: assert property (p_rail) else $error("rail high while idle");
    property p_det; vbus_gate_drive && cc_detach |-> ##[1:2] !vbus_gate_drive; endproperty
    a_det: assert property (p_det) else $error("vbus kept after detach");
    property p_ot;
        overtemp_threshold_one |-> ##[1:2] (overtemp_shutdown && !discharge_pin);
    endproperty
    a_ot: assert property (p_ot) else $error("discharge kept hot");
    property p_slp; $rose(sleep_mode) |-> $past(cc1_above_rd && cc2_above_rd); endproperty
    a_slp: assert property (p_slp) else $error("sleep without open pins");
endmodule // tcs_ctrl_monitor

bind tcs_source_ctrl tcs_ctrl_monitor i_mon (.ref_clk, .reset, .cc1_in_window, .cc2_in_window,
    .cc1_above_rd, .cc2_above_rd, .cc_detach, .vbus_low, .supply_ok, .overtemp_threshold_one,
    .cc1_rp_sel, .cc2_rp_sel, .sleep_mode, .orient_cc2, .vbus_gate_drive,
    .attach_indicator_out_n, .bleed_pulldown, .supply_bleed_current, .discharge_pin,
    .overtemp_shutdown, .tx_bias_rail, .tx_busy);

// [verif/tcs_sink_model.sv]
// sink at the far end of the cc wire; decodes the source's bmc bits
// assumes a half unit of 17 ref_clk cycles
`timescale 1ns/1ns
module tcs_sink_model (
    input  wire        ref_clk,
    input  wire        plugged,
    input  wire        flip,
    input  wire        tx_line,
    input  wire        tx_bias_rail,
    output wire        cc1_in_window,
    output wire        cc2_in_window,
    output wire        cc1_above_rd,
    output wire        cc2_above_rd,
    output reg  [31:0] rx_word,
    output reg  [7:0]  rx_cnt
);
    reg [7:0] gap = 8'h0;
    reg       half = 1'b0;
    reg       last = 1'b0;
    reg       fresh = 1'b1;
    // rd sits on one pin only; an open plug leaves both pins high
    assign cc1_in_window = plugged & ~flip;
    assign cc2_in_window = plugged & flip;
    assign cc1_above_rd  = ~plugged;
    assign cc2_above_rd  = ~plugged;
    always @(posedge ref_clk) begin
        last <= tx_line;
        gap  <= gap + 8'h1;
        if (!tx_bias_rail) begin
            gap   <= 8'h0;
            half  <= 1'b0;
            fresh <= 1'b1;
        end else if (fresh) begin
            rx_cnt <= 8'h0;
            fresh  <= 1'b0;
        end else if (tx_line != last) begin
            gap <= 8'h1;
            // long gap is a zero, two short gaps a one; lsb arrives first
            if (gap > 8'd25 || half) begin
                rx_word <= {~(gap > 8'd25), rx_word[31:1]};
                rx_cnt  <= rx_cnt + 8'h1;
                half    <= 1'b0;
            end else
                half <= 1'b1;
        end
    end
endmodule // tcs_sink_model

// [verif/tcs_source_ctrl_bench.sv]
// bench for the source controller with a sink model on the cc wire
// assumes debounce and discharge counts shortened to 20 and 30 cycles
`timescale 1ns/1ns
module tcs_source_ctrl_bench;
    localparam DEB = 20;
    localparam DSC = 30;
    reg         ref_clk, reset, cc_detach, vbus_low, vbus_safe0, supply_ok, sink_pd_capable;
    reg         contract_done, hi_volt_agreed, overtemp_threshold_one, msg_start, msg_is_caps;
    reg         plugged, flip;
    reg  [31:0] msg_word;
    integer     error_cnt, tests_run, n;
    wire        cc1_in_window, cc2_in_window, cc1_above_rd, cc2_above_rd, sleep_mode;
    wire [1:0]  cc1_rp_sel, cc2_rp_sel;
    wire        orient_cc2, vbus_gate_drive, attach_indicator_out_n, bleed_pulldown, tx_line;
    wire        supply_bleed_current, discharge_pin, overtemp_shutdown, sel_high_volt, tx_busy;
    wire        hard_reset_req, tx_bias_rail;
    wire [31:0] rx_word;
    wire [7:0]  rx_cnt;
    wire        wake_cmp = plugged;
    tcs_source_ctrl #(.DEB_CYC(DEB), .DISCHARGE_PIN_CYC(DSC)) i_dut (.ref_clk, .reset, .cc1_in_window,
        .cc2_in_window, .cc1_above_rd, .cc2_above_rd, .cc_detach, .vbus_low, .vbus_safe0,
        .wake_cmp, .supply_ok, .sink_pd_capable, .contract_done, .hi_volt_agreed,
        .overtemp_threshold_one, .msg_start, .msg_is_caps, .msg_word, .cc1_rp_sel, .cc2_rp_sel,
        .sleep_mode, .orient_cc2, .vbus_gate_drive, .attach_indicator_out_n, .bleed_pulldown,
        .supply_bleed_current, .discharge_pin, .overtemp_shutdown, .sel_high_volt,
        .hard_reset_req, .tx_bias_rail, .tx_line, .tx_busy);
    tcs_sink_model i_sink (.ref_clk, .plugged, .flip, .tx_line, .tx_bias_rail, .cc1_in_window,
        .cc2_in_window, .cc1_above_rd, .cc2_above_rd, .rx_word, .rx_cnt);
    task chk(input ok, input [8*24:1] msg);
        tests_run = tests_run + 1;
        if (!ok) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t %0s", $time, msg);
        end
    endtask
    task cyc(input integer k);
        repeat (k) @(negedge ref_clk);
    endtask
    task conclude;
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task t_attach(input f);
        flip = f;
        plugged = 1;
        cyc(DEB - 5);
        plugged = 0;
        cyc(1);
        plugged = 1;
        cyc(DEB - 2);
        chk(vbus_gate_drive === 1'b0, "debounce kept");
        supply_ok = 0;
        cyc(4);
        chk(vbus_gate_drive === 1'b0, "gate without supply");
        supply_ok = 1;
        for (n = 0; n < 3 * DEB && vbus_gate_drive !== 1'b1; n = n + 1)
            cyc(1);
        chk(attach_indicator_out_n === 1'b0 && vbus_gate_drive === 1'b1, "no attach");
        chk(orient_cc2 === f && {cc1_rp_sel, cc2_rp_sel} === (f ? 4'h2 : 4'h8), "rp");
        chk(bleed_pulldown === 1'b1 && supply_bleed_current === 1'b1, "bleed");
        chk(sel_high_volt === 1'b0, "not 5 v");
    endtask
    task t_msg;
        sink_pd_capable = 1;
        cyc(3);
        chk(cc1_rp_sel === 2'h3, "rp not 1.5a");
        msg_word = 32'hf3ff_a5c3;
        msg_is_caps = 1;
        msg_start = 1;
        cyc(1);
        msg_start = 0;
        cyc(3);
        chk(tx_bias_rail === 1'b1, "rail low");
        for (n = 0; n < 1200 && tx_busy !== 1'b0; n = n + 1)
            cyc(1);
        cyc(2);
        chk(tx_bias_rail === 1'b0, "rail stuck");
        chk(rx_cnt === 8'd32 && rx_word === 32'hf1ff_a5c3, "bmc word");
    endtask
    task t_end;
        {contract_done, hi_volt_agreed} = 2'h3;
        cyc(3);
        chk({bleed_pulldown, supply_bleed_current, sel_high_volt} === 3'h1, "contract");
        {vbus_safe0, cc_detach, plugged} = 3'h2;
        cyc(3);
        chk(vbus_gate_drive === 1'b0, "vbus on");
        chk(discharge_pin === 1'b1, "no discharge");
        overtemp_threshold_one = 1;
        cyc(2);
        chk(overtemp_shutdown === 1'b1 && discharge_pin === 1'b0, "hot discharge");
        overtemp_threshold_one = 0;
        for (n = 0; n < DSC + 5 && hard_reset_req !== 1'b1; n = n + 1)
            cyc(1);
        chk(hard_reset_req === 1'b1, "no hard reset");
        {vbus_safe0, cc_detach, contract_done, hi_volt_agreed, sink_pd_capable} = 5'h10;
        cyc(DEB + 10);
        chk(sleep_mode === 1'b1, "no sleep");
    endtask
    initial begin
        ref_clk = 0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #1000000;
        error_cnt = error_cnt + 1;
        conclude;
    end
    initial begin
        {cc_detach, sink_pd_capable, contract_done, hi_volt_agreed, msg_start} = 5'h0;
        {overtemp_threshold_one, msg_is_caps, plugged, flip, msg_word} = 36'h0;
        {reset, vbus_low, vbus_safe0, supply_ok} = 4'hf;
        error_cnt = 0;
        tests_run = 0;
        cyc(4);
        reset = 0;
        cyc(1);
        chk({cc1_rp_sel, cc2_rp_sel, tx_bias_rail} === 5'ha, "reset");
        t_attach(0);
        t_msg;
        t_end;
        t_attach(1);
        conclude;
    end
endmodule // tcs_source_ctrl_bench
